// *** inc/psx_pkg.sv ***
/*
 Constants and types for the packed SIMD extension datapath.
 Assumes a core decoder that hands over the opcode byte after 0F, the addressing byte
 and an already fetched 64-bit memory operand.
*/
package psx_pkg;
	localparam int PSX_NREG = 8;
	localparam int PSX_WIDTH = 64;
	// Second opcode byte of each handled instruction
	localparam logic [7:0] PSX_OP_AVG = 8'h50;
	localparam logic [7:0] PSX_OP_ADD = 8'h51;
	localparam logic [7:0] PSX_OP_MAG = 8'h52;
	localparam logic [7:0] PSX_OP_DIST = 8'h54;
	localparam logic [7:0] PSX_OP_MULH = 8'h5D;
	localparam logic [7:0] PSX_OP_MAC = 8'h5E;
	localparam logic [7:0] PSX_OP_PACKWB = 8'h63;
	localparam logic [7:0] PSX_OP_PACKDW = 8'h6B;
	// Addressing byte: mod value selecting a register operand
	localparam logic [1:0] PSX_MOD_REG = 2'h3;
	localparam logic [2:0] PSX_IMP_FLIP = 3'h1;
	// Rounding half of bit 15, and the product slice start
	localparam logic [31:0] PSX_RND = 32'h0000_4000;
	localparam int PSX_RND_SHIFT = 15;
	// Clock counts
	localparam int PSX_LAT_ONE = 1;
	localparam int PSX_LAT_TWO = 2;
	typedef enum logic [1:0] {
		PSX_IDLE = 2'h0,
		PSX_HOLD = 2'h1
	} psx_state_type;
endpackage

// *** core/psx_alu.sv ***
/*
 Packed SIMD extension datapath: eight 64-bit packed registers and the extended
 saturating, averaging, distance, multiply and magnitude operations plus the packs.
 Assumes the core decoder issues one instruction at a time and holds off while busy.
*/
module psx_alu
	import psx_pkg::*;
(
	input wire logic clock, // 250 MHz core clock
	input wire logic rst_b, // Synchronous reset, active low
	input wire logic ext_enable, // Extension enable bit from core config
	input wire logic op_valid, // Instruction issue strobe
	input wire logic [7:0] op_code, // Opcode byte following 0F
	input wire logic [7:0] op_modrm, // Addressing byte
	input wire logic [psx_pkg::PSX_WIDTH-1:0] op_mem, // Fetched memory operand
	input wire logic [2:0] rd_index, // Debug read register index
	output logic op_busy, // Two-clock op in flight
	output logic op_done, // Result written, one cycle
	output logic op_invalid, // Invalid opcode exception, one cycle
	output logic [psx_pkg::PSX_WIDTH-1:0] op_result, // Value written
	output logic [2:0] op_dest, // Register written
	output logic [psx_pkg::PSX_WIDTH-1:0] rd_data // Debug read data
);
	import psx_pkg::*;

	typedef struct packed {
		psx_state_type state;
		logic [PSX_NREG-1:0][PSX_WIDTH-1:0] rf;
		logic [PSX_WIDTH-1:0] pend;
		logic [2:0] pend_idx;
		logic busy;
		logic done;
		logic invalid;
		logic [PSX_WIDTH-1:0] result;
		logic [2:0] dest;
		logic [PSX_WIDTH-1:0] rd_data;
	} psx_st_type;

	psx_st_type st;
	psx_st_type next_st;

	// clamp, never wrap
	// Clamp to a signed word; the caller sign-extends from the lane top bit
	function automatic logic [15:0] sat16(input logic signed [33:0] v);
		if (v > 34'sh0_0000_7FFF) return 16'h7FFF;
		if (v < -34'sh0_0000_8000) return 16'h8000;
		return v[15:0];
	endfunction

	function automatic logic [7:0] sat8(input logic signed [15:0] v);
		if (v > 16'sh007F) return 8'h7F;
		if (v < -16'sh0080) return 8'h80;
		return v[7:0];
	endfunction

	function automatic logic [7:0] satu8(input logic [9:0] v);
		return (v > 10'h0FF) ? 8'hFF : v[7:0];
	endfunction

	// Magnitude of a signed word, one bit wider so 8000 fits
	function automatic logic [16:0] mag16(input logic [15:0] v);
		return v[15] ? (17'h1_0000 - {1'b0, v}) : {1'b0, v};
	endfunction

	// Shared decode of the issue fields
	logic [1:0] md;
	logic [2:0] ri;
	logic [2:0] mi;
	logic [2:0] imp;
	logic [PSX_WIDTH-1:0] a;
	logic [PSX_WIDTH-1:0] b;
	logic [PSX_WIDTH-1:0] d;
	logic issue;
	logic is_ext;
	assign md = op_modrm[7:6];
	assign ri = op_modrm[5:3];
	assign mi = op_modrm[2:0];
	assign imp = ri ^ PSX_IMP_FLIP;
	assign a = st.rf[ri];
	assign b = (md == PSX_MOD_REG) ? st.rf[mi] : op_mem;
	assign d = st.rf[imp];
	assign issue = op_valid && !st.busy;
	assign is_ext = (op_code == PSX_OP_AVG) || (op_code == PSX_OP_ADD)
		|| (op_code == PSX_OP_MAG) || (op_code == PSX_OP_DIST)
		|| (op_code == PSX_OP_MULH) || (op_code == PSX_OP_MAC);

	// Next-state: one-clock ops write at issue, two-clock ops park the result for a cycle
	always_comb begin
		logic ok;
		logic two;
		logic [2:0] dst;
		logic [PSX_WIDTH-1:0] res;
		logic signed [31:0] prod;
		logic [8:0] diff;
		ok = 1'b1;
		two = 1'b0;
		dst = ri;
		res = '0;
		prod = '0;
		diff = '0;
		next_st = st;
		next_st.done = 1'b0;
		next_st.invalid = 1'b0;
		next_st.rd_data = st.rf[rd_index];
		case (st.state)
			PSX_IDLE: begin
				if (op_valid) begin
					case (op_code)
						PSX_OP_ADD: begin
							dst = imp;
							for (int w = 0; w < 4; w++) begin
								res[w*16+:16] = sat16(34'($signed(a[w*16+:16]))
									+ 34'($signed(b[w*16+:16])));
							end
						end
						PSX_OP_AVG: begin
							for (int i = 0; i < 8; i++) begin
								diff = {1'b0, a[i*8+:8]} + {1'b0, b[i*8+:8]} + 9'h001;
								res[i*8+:8] = diff[8:1];
							end
						end
						PSX_OP_DIST: begin
							two = 1'b1;
							dst = imp;
							ok = (md != PSX_MOD_REG);
							for (int i = 0; i < 8; i++) begin
								diff = (b[i*8+:8] >= a[i*8+:8]) ? {1'b0, b[i*8+:8] - a[i*8+:8]}
									: {1'b0, a[i*8+:8] - b[i*8+:8]};
								res[i*8+:8] = satu8({2'b00, d[i*8+:8]} + {1'b0, diff});
							end
						end
						// rounded product accumulate into implied words
						PSX_OP_MAC: begin
							two = 1'b1;
							dst = imp;
							ok = (md != PSX_MOD_REG);
							for (int w = 0; w < 4; w++) begin
								prod = $signed(a[w*16+:16]) * $signed(b[w*16+:16]);
								// Rounding constant kept signed so the shift stays arithmetic
								res[w*16+:16] = sat16(34'($signed(d[w*16+:16]))
									+ ((34'(prod) + $signed(34'(PSX_RND))) >>> PSX_RND_SHIFT));
							end
						end
						// larger magnitude wins, tie keeps register
						PSX_OP_MAG: begin
							two = 1'b1;
							for (int w = 0; w < 4; w++) begin
								res[w*16+:16] = (mag16(a[w*16+:16]) >= mag16(b[w*16+:16]))
									? a[w*16+:16] : b[w*16+:16];
							end
						end
						PSX_OP_MULH: begin
							two = 1'b1;
							dst = imp;
							for (int w = 0; w < 4; w++) begin
								prod = $signed(a[w*16+:16]) * $signed(b[w*16+:16]) + $signed(PSX_RND);
								res[w*16+:16] = prod[30:15];
							end
						end
						// destination dwords low, source dwords high
						PSX_OP_PACKDW: begin
							for (int k = 0; k < 2; k++) begin
								res[k*16+:16] = sat16(34'($signed(a[k*32+:32])));
								res[32+k*16+:16] = sat16(34'($signed(b[k*32+:32])));
							end
						end
						// destination words low, source words high
						PSX_OP_PACKWB: begin
							for (int w = 0; w < 4; w++) begin
								res[w*8+:8] = sat8($signed(a[w*16+:16]));
								res[32+w*8+:8] = sat8($signed(b[w*16+:16]));
							end
						end
						default: ok = 1'b0;
					endcase
					if (is_ext && !ext_enable) begin
						ok = 1'b0;
					end
					if (!ok) begin
						next_st.invalid = 1'b1;
					end else if (two) begin
						next_st.state = PSX_HOLD;
						next_st.busy = 1'b1;
						next_st.pend = res;
						next_st.pend_idx = dst;
					end else begin
						next_st.rf[dst] = res;
						next_st.done = 1'b1;
						next_st.result = res;
						next_st.dest = dst;
					end
				end
			end
			PSX_HOLD: begin
				// Second clock of a two-clock op: sources were read at issue
				next_st.rf[st.pend_idx] = st.pend;
				next_st.done = 1'b1;
				next_st.result = st.pend;
				next_st.dest = st.pend_idx;
				next_st.busy = 1'b0;
				next_st.state = PSX_IDLE;
			end
			default: begin
				next_st.state = PSX_IDLE;
				next_st.busy = 1'b0;
			end
		endcase
	end

	// State register; reset clears registers and all strobes
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign op_busy = st.busy;
	assign op_done = st.done;
	assign op_invalid = st.invalid;
	assign op_result = st.result;
	assign op_dest = st.dest;
	assign rd_data = st.rd_data;

	a_add_dest_implied: assert property (@(posedge clock) disable iff (!rst_b)
		issue && op_code == PSX_OP_ADD && ext_enable |=> op_done && op_dest == $past(imp))
		else $error("add did not write implied register");
	a_disabled_traps: assert property (@(posedge clock) disable iff (!rst_b)
		issue && is_ext && !ext_enable |=> op_invalid && !op_done && !op_busy)
		else $error("disabled extended op not trapped");
	a_mag_two_clock: assert property (@(posedge clock) disable iff (!rst_b)
		issue && op_code == PSX_OP_MAG && ext_enable |=> op_busy && !op_done ##1 op_done)
		else $error("magnitude select not two clocks");
	a_avg_one_clock: assert property (@(posedge clock) disable iff (!rst_b)
		issue && op_code == PSX_OP_AVG && ext_enable |=> op_done && !op_busy)
		else $error("average not one clock");
	a_dist_mem_only: assert property (@(posedge clock) disable iff (!rst_b)
		issue && op_code == PSX_OP_DIST && md == PSX_MOD_REG |=> op_invalid)
		else $error("register form of distance accepted");
	a_mac_mem_only: assert property (@(posedge clock) disable iff (!rst_b)
		issue && op_code == PSX_OP_MAC && md == PSX_MOD_REG |=> op_invalid)
		else $error("register form of multiply accumulate accepted");
	a_add_no_wrap: assert property (@(posedge clock) disable iff (!rst_b)
		issue && op_code == PSX_OP_ADD && ext_enable && !a[15] && !b[15]
		|=> !op_result[15])
		else $error("positive sum wrapped negative");
	a_sources_kept: assert property (@(posedge clock) disable iff (!rst_b)
		issue && op_code == PSX_OP_ADD && ext_enable |=> st.rf[$past(ri)] == $past(a))
		else $error("implied add changed its source");
	a_avg_reg_form: assert property (@(posedge clock) disable iff (!rst_b)
		issue && op_code == PSX_OP_AVG && ext_enable && md == PSX_MOD_REG && ri == mi
		|=> op_result == $past(a))
		else $error("self average not identity");
	a_packwb_halves: assert property (@(posedge clock) disable iff (!rst_b)
		issue && op_code == PSX_OP_PACKWB && md == PSX_MOD_REG && ri == mi
		|=> op_result[31:0] == op_result[63:32])
		else $error("byte pack halves differ");
endmodule

// *** tb/psx_issue_model.sv ***
/*
 Decoder and operand fetch model that issues one instruction at a time.
 Assumes the caller enters just after a rising edge and waits for completion.
*/
module psx_issue_model
	import psx_pkg::*;
(
	input wire logic clock, // Core clock
	output logic op_valid, // Issue strobe
	output logic [7:0] op_code, // Opcode after 0F
	output logic [7:0] op_modrm, // Addressing byte
	output logic [psx_pkg::PSX_WIDTH-1:0] op_mem // Memory operand
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle bus at time zero
	initial begin
		op_valid = 1'b0;
		op_code = 8'h00;
		op_modrm = 8'h00;
		op_mem = '0;
	end
	// memory operand driven whatever the mod field; the datapath picks by mod
	// Held over one taking edge; released lines show no stale value
	task automatic issue(input logic [7:0] c, md, input logic [63:0] m);
		op_valid = 1'b1;
		op_code = c;
		op_modrm = md;
		op_mem = m;
		@(posedge clock);
		#1;
		op_valid = 1'b0;
		op_code = ~c;
		op_modrm = ~md;
		op_mem = ~m;
	endtask
endmodule

// *** tb/test_packed_simd_extension_alu.sv ***
/*
 Self-checking bench for the packed SIMD extension datapath.
 Assumes registers clear on reset and the issue model in its own file.
*/
module test_packed_simd_extension_alu;
	timeunit 1ns;
	timeprecision 1ps;
	import psx_pkg::*;
	localparam logic [63:0] A = 64'h7FFF_8000_0001_FFFF;
	localparam logic [63:0] M = 64'h8000_7FFF_FFFF_0001;
	logic clock, rst_b, ext_enable, op_valid, op_busy, op_done, op_invalid;
	logic [7:0] op_code, op_modrm;
	logic [2:0] rd_index, op_dest;
	logic [63:0] op_mem, op_result, rd_data;
	int error_cnt = 0, checks_done = 0, cyc = 0;
	psx_alu psx_alu_i(.clock(clock), .rst_b(rst_b), .ext_enable(ext_enable),
		.op_valid(op_valid), .op_code(op_code), .op_modrm(op_modrm), .op_mem(op_mem),
		.rd_index(rd_index), .op_busy(op_busy), .op_done(op_done), .op_invalid(op_invalid),
		.op_result(op_result), .op_dest(op_dest), .rd_data(rd_data));
	psx_issue_model psx_issue_model_i(.clock(clock), .op_valid(op_valid),
		.op_code(op_code), .op_modrm(op_modrm), .op_mem(op_mem));
	// 250 MHz clock
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	function automatic longint cl(input longint v, lo, hi);
		return v < lo ? lo : (v > hi ? hi : v);
	endfunction
	function automatic longint sw(input logic [63:0] x, input int i, w);
		return w == 16 ? longint'($signed(x[i*16+:16])) : longint'($signed(x[i*32+:32]));
	endfunction
	// Lane model; wide sums kept in longint so clamping sees the true value
	function automatic logic [63:0] ref_op(input logic [7:0] c, input logic [63:0] a, b, m);
		logic [63:0] r;
		longint s, t, u, p;
		r = '0;
		for (int i = 0; i < 8; i++) begin
			s = a[i*8+:8];
			t = b[i*8+:8];
			u = m[i*8+:8];
			if (c == 8'h50) r[i*8+:8] = 8'((s + t + 1) >> 1);
			if (c == 8'h54) r[i*8+:8] = 8'(cl(u + (s > t ? s - t : t - s), 0, 255));
			if (c == 8'h63) r[i*8+:8] = 8'(cl(i < 4 ? sw(a, i, 16) : sw(b, i - 4, 16), -128, 127));
			if (i < 4) begin
				s = sw(a, i, 16);
				t = sw(b, i, 16);
				u = sw(m, i, 16);
				p = s * t + 16384;
				case (c)
					8'h51: r[i*16+:16] = 16'(cl(s + t, -32768, 32767));
					8'h52: r[i*16+:16] = 16'(((t < 0) ? -t : t) > ((s < 0) ? -s : s) ? t : s);
					8'h5D: r[i*16+:16] = 16'(p >>> 15);
					8'h5E: r[i*16+:16] = 16'(cl(u + (p >>> 15), -32768, 32767));
					8'h6B: r[i*16+:16] = 16'(cl(i < 2 ? sw(a, i, 32) : sw(b, i - 2, 32), -32768, 32767));
					default: ;
				endcase
			end
		end
		return r;
	endfunction
	task automatic chk(input string n, input logic [63:0] s, e);
		checks_done++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic final_report;
		$display("Checks %0d, mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic rst(input int n);
		rst_b = 1'b0;
		repeat (n) @(posedge clock);
		#1;
		rst_b = 1'b1;
	endtask
	// Issue and judge timing, value and target; lat 0 means refused
	task automatic ex(input logic [7:0] c, md, input logic [63:0] m, input int lat,
		input logic [63:0] e, input logic [2:0] d);
		psx_issue_model_i.issue(c, md, m);
		if (lat == 0) begin
			chk("invalid", op_invalid, 1'b1);
			chk("done", op_done, 1'b0);
		end else begin
			if (lat == 2) begin
				chk("busy", op_busy, 1'b1);
				@(posedge clock);
				#1;
			end
			chk("done", op_done, 1'b1);
			chk("result", op_result, e);
			chk("dest", op_dest, d);
		end
		@(posedge clock);
		#1;
		chk("pulse", op_done | op_invalid, 1'b0);
	endtask
	task automatic rd(input logic [2:0] i, input logic [63:0] e);
		rd_index = i;
		repeat (2) @(posedge clock);
		#1;
		chk("reg", rd_data, e);
	endtask
	// Register 2 is clear after reset, so the sum lands in 3 unchanged
	task automatic ld(input logic [63:0] v);
		rst(2);
		ex(8'h51, 8'h10, v, 1, v, 3'h3);
	endtask
	task automatic t_add;
		ld(A);
		ex(8'h51, 8'hDB, 64'h0, 1, ref_op(8'h51, A, A, 0), 3'h2);
		rd(3'h3, A);
		// Positive low lane keeps its sign; the top lanes clamp
		ld(M);
		ex(8'h51, 8'hDB, 64'h0, 1, ref_op(8'h51, M, M, 0), 3'h2);
	endtask
	task automatic t_avg_mag;
		logic [63:0] e;
		ld(A);
		ex(8'h52, 8'h18, M, 2, ref_op(8'h52, A, M, 0), 3'h3);
		ld(A);
		e = ref_op(8'h50, A, M, 0);
		ex(8'h50, 8'h18, M, 1, e, 3'h3);
		// Register form, same register twice: the average is the value itself
		ex(8'h50, 8'hDB, 64'h0, 1, ref_op(8'h50, e, e, 0), 3'h3);
	endtask
	task automatic t_dist;
		logic [63:0] e;
		ld(A);
		e = ref_op(8'h54, A, M, 0);
		ex(8'h54, 8'h18, M, 2, e, 3'h2);
		ex(8'h54, 8'h18, M, 2, ref_op(8'h54, A, M, e), 3'h2);
		ex(8'h54, 8'hDB, M, 0, 0, 3'h0);
	endtask
	task automatic t_mul;
		logic [63:0] e;
		ld(A);
		e = ref_op(8'h5D, A, M, 0);
		ex(8'h5D, 8'h18, M, 2, e, 3'h2);
		ex(8'h5E, 8'h18, M, 2, ref_op(8'h5E, A, M, e), 3'h2);
		ex(8'h5E, 8'hDB, M, 0, 0, 3'h0);
	endtask
	// Packs run with the extension off; extended codes are refused
	task automatic t_pack;
		logic [63:0] e;
		ld(A);
		ext_enable = 1'b0;
		ex(8'h51, 8'h18, M, 0, 0, 3'h0);
		rd(3'h2, 64'h0);
		ex(8'h00, 8'h18, M, 0, 0, 3'h0);
		e = ref_op(8'h6B, A, M, 0);
		ex(8'h6B, 8'h18, M, 1, e, 3'h3);
		e = ref_op(8'h63, e, M, 0);
		ex(8'h63, 8'h18, M, 1, e, 3'h3);
		ex(8'h63, 8'hDB, 64'h0, 1, ref_op(8'h63, e, e, 0), 3'h3);
		ext_enable = 1'b1;
	endtask
	// Hang guard
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			final_report;
		end
	end
	// Main sequence
	initial begin
		ext_enable = 1'b1;
		rd_index = 3'h0;
		rst_b = 1'b0;
		@(posedge clock);
		#1;
		rst(20);
		t_add;
		t_avg_mag;
		t_dist;
		t_mul;
		t_pack;
		final_report;
	end
endmodule
